// >>> hdl/vst_pkg.sv
// Shared constants and types for the video sync timing output block
package vst_pkg;

    // Sampling clock period in picoseconds (200 MHz)
    localparam int CLK_PERIOD_PS = 5000;

    // Least time in ns to whole sampling cycles, rounded up, never below one
    function automatic int ns_to_cyc(input int ns);
        int cyc;
        cyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    // Pulse width counters
    localparam int PW_W               = 12;
    // Synthesised line sync width used inside the vertical interval
    localparam int LINE_SYNC_WIDTH_NS = 4700;
    localparam int LINE_SYNC_CYC      = ns_to_cyc(LINE_SYNC_WIDTH_NS);
    // Back porch gate widths: burst, short (serration / ED), HD
    localparam int BP_BURST_NS        = 2500;
    localparam int BP_SHORT_NS        = 1000;
    localparam int BP_HD_NS           = 500;
    localparam int BP_BURST_CYC       = ns_to_cyc(BP_BURST_NS);
    localparam int BP_SHORT_CYC       = ns_to_cyc(BP_SHORT_NS);
    localparam int BP_HD_CYC          = ns_to_cyc(BP_HD_NS);

    // Field sync pulse width in lines
    localparam int FIELD_SYNC_LINES   = 3;
    // Format word: width and first line sync that carries it
    localparam int FMT_BITS           = 11;
    localparam int FMT_START_LINE     = 3;
    // Buffer of captured line counts
    localparam int WORD_FIFO_DEPTH    = 8;

    // Reset (no-signal) levels of the outputs
    localparam logic OUT_IDLE_LEVEL   = 1'b1;

    typedef enum logic [1:0] {
        VST_FMT_SD = 2'b00,
        VST_FMT_ED = 2'b01,
        VST_FMT_HD = 2'b10
    } vst_format_t;

    typedef enum logic [1:0] {
        VST_SER_IDLE  = 2'b00,
        VST_SER_WAIT  = 2'b01,
        VST_SER_SHIFT = 2'b10
    } vst_ser_state_t;

endpackage

// >>> hdl/vst_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module vst_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wrap_inc(wr_ptr) : wr_ptr;
            rd_ptr <= pop ? wrap_inc(rd_ptr) : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

`default_nettype wire

// >>> hdl/vst_timing_out.sv
// Video sync timing outputs: composite, line, field, back porch, parity, format word
//
// Function
// RQ1: No video: line, field, porch outputs high.
// RQ2: Composite output copies every below-blanking sync.
// RQ3: Line sync falls after sync reference point.
// RQ4: Vertical interval: line sync trailing edge synthesised.
// RQ5: Receiver uses only falling line sync edge.
// RQ6: Field sync falls at serration, lasts 3 lines.
// RQ7: Back porch gate pulses low after sync.
// RQ8: SD porch after sync rise, burst width. Code uses the short width inside the vertical interval.
// RQ9: ED porch always uses the short width.
// RQ10: HD porch after tri-level trailing fall, narrowest.
// RQ11: Interlaced parity high field 1, low field 2.
// RQ12: Parity changes only at field sync fall.
// RQ13: Progressive formats hold parity output high.
// RQ14: Count line syncs per field, 11 bits.
// RQ15: Shift word out from third line sync on.
// RQ16: Word output undefined outside its 11 slots.
// RQ17: Lines inside field sync are not counted.
// RQ18: Receiver clocks word with line sync, enabled by field.
// RQ19: Word goes out most significant bit first.
// RQ20: Counter cleared at field sync, word buffered.
// RQ21: Sync strobes on fast clock, reset to idle.
`timescale 1ns/1ps
`default_nettype none

module vst_timing_out (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // Sliced input levels, asynchronous to ref_clk
    input  wire logic                 sync_tip_in,
    input  wire logic                 tri_pos_in,
    input  wire logic                 video_present_in,
    input  wire logic                 vert_interval_in,
    input  wire logic                 field_two_in,
    // Slicer strobe, one ref_clk cycle
    input  wire logic                 serration_mid_stb,
    // Format setup, static on ref_clk
    input  wire vst_pkg::vst_format_t format_sel,
    input  wire logic                 interlaced,
    // Timing outputs, all active low except parity and the format word
    output logic                      composite_sync_out,
    output logic                      line_sync_out,
    output logic                      field_sync_out,
    output logic                      back_porch_gate_out,
    output logic                      field_parity_out,
    output logic                      format_word_serial_out
);
    import vst_pkg::*;

    localparam int NA = 5;
    // Two-stage synchronisers plus one history stage for edges
    logic [NA-1:0] meta;
    logic [NA-1:0] stage;
    logic [NA-1:0] stage_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta    <= '0;
            stage   <= '0;
            stage_q <= '0;
        end else begin
            meta    <= {field_two_in, vert_interval_in, video_present_in,
                        tri_pos_in, sync_tip_in};
            stage   <= meta;
            stage_q <= stage;
        end
    end

    logic present;
    logic vint;
    logic field_two;
    logic sync_fall;
    logic sync_rise;
    logic tri_rise;
    logic tri_fall;
    logic is_hd;
    logic line_ref;

    assign present   = stage[2];
    assign vint      = stage[3];
    assign field_two = stage[4];
    assign sync_fall = stage[0] & ~stage_q[0];
    assign sync_rise = ~stage[0] & stage_q[0];
    assign tri_rise  = stage[1] & ~stage_q[1];
    assign tri_fall  = ~stage[1] & stage_q[1];
    assign is_hd     = (format_sel == VST_FMT_HD);
    // Tri-level reference is the zero crossing into the positive tip
    assign line_ref  = is_hd ? tri_rise : sync_fall;
    // Composite sync: not forced while video is absent
    logic next_composite;
    // RQ2 composite sync copy
    assign next_composite = ~stage[0];
    // Line sync
    logic [PW_W-1:0] line_cnt;
    logic [PW_W-1:0] next_line_cnt;
    logic            line_trail;
    logic            line_end;
    logic            next_line_sync;

    assign line_trail = is_hd ? tri_fall : sync_rise;
    // RQ4 synthesised trailing edge
    assign line_end   = vint ? (line_cnt == '0) : line_trail;
    // RQ1 RQ3 idle high, falling reference edge
    assign next_line_sync = ~present ? OUT_IDLE_LEVEL :
                            line_ref ? 1'b0 :
                            (~line_sync_out & line_end) ? 1'b1 : line_sync_out;
    assign next_line_cnt  = line_ref ? PW_W'(LINE_SYNC_CYC - 1) :
                            (line_cnt != '0) ? line_cnt - PW_W'(1) : '0;

    // Field sync
    logic [1:0] vs_lines;
    logic [1:0] next_vs_lines;
    logic       vs_start;
    logic       vs_last;
    logic       next_field_sync;

    assign vs_start = serration_mid_stb & field_sync_out & present;
    assign vs_last  = line_ref & (vs_lines == 2'(FIELD_SYNC_LINES - 1));
    // RQ6 fall and three-line width
    assign next_field_sync = ~present ? OUT_IDLE_LEVEL :
                             vs_start ? 1'b0 :
                             (~field_sync_out & vs_last) ? 1'b1 : field_sync_out;
    assign next_vs_lines   = (field_sync_out | vs_last) ? 2'b00 :
                             line_ref ? vs_lines + 2'b01 : vs_lines;

    // Back porch gate
    logic [PW_W-1:0] bp_cnt;
    logic [PW_W-1:0] next_bp_cnt;
    logic [PW_W-1:0] bp_width;
    logic            bp_trig;
    logic            next_bp_gate;

    // RQ8 RQ10 porch trigger edge
    assign bp_trig  = is_hd ? tri_fall : sync_rise;
    // RQ9 width per format
    assign bp_width = is_hd ? PW_W'(BP_HD_CYC) :
                      ((format_sel == VST_FMT_ED) | vint) ? PW_W'(BP_SHORT_CYC) :
                      PW_W'(BP_BURST_CYC);
    assign next_bp_cnt  = bp_trig ? bp_width - PW_W'(1) :
                          (bp_cnt != '0) ? bp_cnt - PW_W'(1) : '0;
    // RQ7 fixed-width low pulse
    assign next_bp_gate = ~present | (~bp_trig & (bp_cnt == '0));

    // Field parity: moves only with the field sync fall, so a change of
    // the interlaced setting takes effect at the next field
    logic next_parity;
    // RQ11 RQ12 RQ13 parity update
    assign next_parity = vs_start ? (~interlaced | ~field_two) : field_parity_out;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // RQ21 idle levels
            composite_sync_out  <= OUT_IDLE_LEVEL;
            line_sync_out       <= OUT_IDLE_LEVEL;
            field_sync_out      <= OUT_IDLE_LEVEL;
            back_porch_gate_out <= OUT_IDLE_LEVEL;
            field_parity_out    <= OUT_IDLE_LEVEL;
            line_cnt            <= '0;
            vs_lines            <= '0;
            bp_cnt              <= '0;
        end else begin
            composite_sync_out  <= next_composite;
            line_sync_out       <= next_line_sync;
            field_sync_out      <= next_field_sync;
            back_porch_gate_out <= next_bp_gate;
            field_parity_out    <= next_parity;
            line_cnt            <= next_line_cnt;
            vs_lines            <= next_vs_lines;
            bp_cnt              <= next_bp_cnt;
        end
    end

    // Lines per field
    logic [FMT_BITS-1:0] line_count;
    logic [FMT_BITS-1:0] next_line_count;
    logic [FMT_BITS-1:0] pend_word;
    logic                pend_valid;
    logic                next_pend_valid;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [FMT_BITS-1:0] fifo_out_data;

    // RQ14 RQ17 count outside field sync, saturating
    assign next_line_count = vs_start ? '0 :
                             (line_ref & field_sync_out & (line_count != '1)) ?
                             line_count + FMT_BITS'(1) : line_count;
    // RQ20 capture held until the buffer accepts it
    assign next_pend_valid = vs_start | (pend_valid & ~fifo_in_ready);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_count <= '0;
            pend_word  <= '0;
            pend_valid <= 1'b0;
        end else begin
            line_count <= next_line_count;
            pend_word  <= vs_start ? line_count : pend_word;
            pend_valid <= next_pend_valid;
        end
    end

    vst_fifo #(
        .WIDTH (FMT_BITS),
        .DEPTH (WORD_FIFO_DEPTH)
    ) u_word_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (pend_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Serialiser
    vst_ser_state_t      ser_state;
    vst_ser_state_t      next_ser_state;
    logic [3:0]          hcnt;
    logic [3:0]          next_hcnt;
    logic [3:0]          bits_sent;
    logic [3:0]          next_bits_sent;
    logic [FMT_BITS-1:0] shreg;
    logic [FMT_BITS-1:0] next_shreg;
    logic                next_fmt_bit;
    logic                load_word;
    logic                shift_edge;
    logic                word_msb;

    // RQ15 third line sync after field sync fall
    assign load_word  = (ser_state == VST_SER_WAIT) & line_ref & ~vs_start &
                        (hcnt == 4'(FMT_START_LINE - 1));
    assign shift_edge = (ser_state == VST_SER_SHIFT) & line_ref & ~vs_start;
    assign fifo_out_ready = load_word;
    assign word_msb   = fifo_out_data[FMT_BITS-1];

    always_comb begin
        next_ser_state = ser_state;
        case (ser_state)
            VST_SER_IDLE: begin
                next_ser_state = VST_SER_IDLE;
            end
            VST_SER_WAIT: begin
                if (load_word) begin
                    next_ser_state = fifo_out_valid ? VST_SER_SHIFT : VST_SER_IDLE;
                end
            end
            VST_SER_SHIFT: begin
                if (shift_edge && bits_sent == 4'(FMT_BITS - 1)) begin
                    next_ser_state = VST_SER_IDLE;
                end
            end
            default: begin
                next_ser_state = VST_SER_IDLE;
            end
        endcase
        if (vs_start) begin
            next_ser_state = VST_SER_WAIT;
        end
    end

    assign next_hcnt      = vs_start ? 4'h0 :
                            ((ser_state == VST_SER_WAIT) & line_ref) ? hcnt + 4'h1 : hcnt;
    assign next_bits_sent = load_word ? 4'h1 : shift_edge ? bits_sent + 4'h1 : bits_sent;
    assign next_shreg     = load_word ? fifo_out_data :
                            shift_edge ? {shreg[FMT_BITS-2:0], 1'b0} : shreg;
    // RQ16 RQ19 msb first, held between slots
    assign next_fmt_bit   = (load_word & fifo_out_valid) ? word_msb :
                            shift_edge ? shreg[FMT_BITS-2] : format_word_serial_out;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ser_state              <= VST_SER_IDLE;
            hcnt                   <= 4'h0;
            bits_sent              <= 4'h0;
            shreg                  <= '0;
            format_word_serial_out <= OUT_IDLE_LEVEL;
        end else begin
            ser_state              <= next_ser_state;
            hcnt                   <= next_hcnt;
            bits_sent              <= next_bits_sent;
            shreg                  <= next_shreg;
            format_word_serial_out <= next_fmt_bit;
        end
    end

    // Checks
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_idle_outputs_high: assert property ( // RQ1
        !present |=> line_sync_out && field_sync_out && back_porch_gate_out)
        else $error("outputs not high without video");
    a_composite_follows: assert property ( // RQ2
        sync_fall |=> !composite_sync_out ##1 1)
        else $error("composite sync missed a sync pulse");
    a_line_fall_ref: assert property ( // RQ3
        line_ref && present |=> !line_sync_out)
        else $error("line sync did not fall on reference");
    a_line_synth_hold: assert property ( // RQ4
        !line_sync_out && vint && line_cnt != '0 && present && !line_ref
        |=> !line_sync_out)
        else $error("line sync released early in vertical interval");
    a_field_sync_start: assert property ( // RQ6
        vs_start |=> !field_sync_out)
        else $error("field sync did not fall at serration");
    a_field_sync_len: assert property ( // RQ6
        $rose(field_sync_out) && $past(present)
        |-> $past(vs_lines) == 2'(FIELD_SYNC_LINES - 1) && $past(line_ref))
        else $error("field sync width not three lines");
    a_porch_start: assert property ( // RQ7
        bp_trig && present |=> !back_porch_gate_out)
        else $error("back porch gate did not start");
    a_porch_ed_short: assert property ( // RQ9
        bp_trig && present && format_sel == VST_FMT_ED
        |=> bp_cnt == PW_W'(BP_SHORT_CYC - 1))
        else $error("ED porch width not short");
    a_parity_at_vsync: assert property ( // RQ12
        $changed(field_parity_out) |-> $past(vs_start))
        else $error("parity changed outside field sync fall");
    a_parity_prog: assert property ( // RQ13
        vs_start && !interlaced |=> field_parity_out)
        else $error("progressive parity not high");
    a_count_clear: assert property ( // RQ20
        vs_start |=> line_count == '0 && pend_valid && pend_word == $past(line_count))
        else $error("line count not captured and cleared");
    a_word_msb_first: assert property ( // RQ19
        load_word && fifo_out_valid |=> format_word_serial_out == $past(word_msb))
        else $error("format word did not start with msb");

    // Third reference lies more than a thousand cycles after the strobe
    c_word_loaded: cover property (load_word && fifo_out_valid);
    c_word_done: cover property (shift_edge && bits_sent == 4'(FMT_BITS - 1));
    c_porch_vint: cover property (bp_trig && vint && !is_hd);
    c_parity_low: cover property ($fell(field_parity_out));
endmodule

`default_nettype wire

// >>> sim/vst_fmt_decoder.sv
// Downstream decoder model: recovers the serial line-count word
`timescale 1ns/1ps
`default_nettype none

module vst_fmt_decoder #(
    parameter int SAMPLE_NS = 1500
) (
    // Timing inputs from the block
    input  wire logic   line_sync_n,
    input  wire logic   field_sync_n,
    input  wire logic   word_bit,
    // Recovered word
    output logic [10:0] rx_word,
    output logic [7:0]  rx_count
);
    int          slot;
    logic [10:0] shreg;

    initial begin
        slot     = 0;
        shreg    = 11'h000;
        rx_word  = 11'h000;
        rx_count = 8'h00;
    end

    always @(negedge field_sync_n) begin
        slot = 0;
    end

    // only the falling line sync edge clocks the decoder
    always @(negedge line_sync_n) begin
        slot = slot + 1;
        // sample mid-line, away from bit changes, in the 11 slots only
        if (slot >= 3 && slot <= 13) begin
            #(SAMPLE_NS);
            shreg = {shreg[9:0], word_bit};
            if (slot == 13) begin
                rx_word  = shreg;
                rx_count = rx_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_vst_timing_out.sv
// Self-checking bench for the video sync timing output block
`timescale 1ns/1ps
`default_nettype none

module test_vst_timing_out;
    import vst_pkg::*;

    logic        ref_clk, sys_rst, lnk_clk;
    logic        sync_tip_in, tri_pos_in, video_present_in;
    logic        vert_interval_in, field_two_in, serration_mid_stb;
    logic        interlaced;
    vst_format_t format_sel;
    logic        cs, ls, fs, bp, par, fw;
    logic [10:0] rx_word;
    logic [31:0] lfsr;
    int          n_mismatch, n_checks, bp_run, bp_last;
    int          exp_q[$];

    always #2.5 ref_clk = ~ref_clk;
    // Source timing runs off its own unrelated clock
    initial begin
        lnk_clk = 1'h0;
        #13;
        forever #40 lnk_clk = ~lnk_clk;
    end

    vst_timing_out dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sync_tip_in(sync_tip_in),
        .tri_pos_in(tri_pos_in), .video_present_in(video_present_in),
        .vert_interval_in(vert_interval_in), .field_two_in(field_two_in),
        .serration_mid_stb(serration_mid_stb), .format_sel(format_sel),
        .interlaced(interlaced), .composite_sync_out(cs), .line_sync_out(ls),
        .field_sync_out(fs), .back_porch_gate_out(bp), .field_parity_out(par),
        .format_word_serial_out(fw)
    );

    vst_fmt_decoder u_dec (
        .line_sync_n(ls), .field_sync_n(fs), .word_bit(fw),
        .rx_word(rx_word), .rx_count()
    );

    // Width of the last low pulse on the porch gate
    always @(posedge ref_clk) begin
        if (bp === 1'h0) begin
            bp_run <= bp_run + 1;
        end else if (bp_run != 0) begin
            bp_last <= bp_run;
            bp_run  <= 0;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One line: sync pulse, then blanking and active video
    task automatic line(input logic vi, input int per);
        int bpw;
        vert_interval_in = vi;
        @(posedge lnk_clk);
        sync_tip_in = 1'h1;
        repeat (4) @(negedge ref_clk);
        chk1(cs, 1'h0);
        if (format_sel == VST_FMT_HD) begin
            repeat (4) @(posedge lnk_clk);
            sync_tip_in = 1'h0;
            tri_pos_in  = 1'h1;
            repeat (4) @(negedge ref_clk);
            chk1(ls, ~video_present_in);
            chk1(cs, 1'h1);
            repeat (4) @(posedge lnk_clk);
            tri_pos_in = 1'h0;
        end else begin
            chk1(ls, ~video_present_in);
            repeat (8) @(posedge lnk_clk);
            sync_tip_in = 1'h0;
        end
        repeat (4) @(negedge ref_clk);
        chk1(cs, 1'h1);
        chk1(ls, ~(vi & video_present_in));
        chk1(bp, ~video_present_in);
        repeat (per - 8) @(posedge lnk_clk);
        if (!video_present_in) bpw = 0;
        else if (format_sel == VST_FMT_HD) bpw = BP_HD_CYC;
        else if (vi || format_sel == VST_FMT_ED) bpw = BP_SHORT_CYC;
        else bpw = BP_BURST_CYC;
        check(16'(bp_last), 16'(bpw));
        bp_last = 0;
    endtask

    task automatic field(input int nl, input logic vi);
        logic f2;
        lfsr = lfsr_next(lfsr);
        f2   = lfsr[0];
        @(negedge ref_clk);
        field_two_in = f2;
        repeat (4) @(negedge ref_clk);
        serration_mid_stb = 1'h1;
        @(negedge ref_clk);
        serration_mid_stb = 1'h0;
        @(negedge ref_clk);
        chk1(fs, ~video_present_in);
        if (video_present_in) chk1(par, interlaced ? ~f2 : 1'h1);
        for (int k = 1; k <= nl; k++) begin
            line(vi && k < 3, (vi && k < 3) ? 64 : 44);
            if (k == 2) chk1(fs, ~video_present_in);
            if (k == 4) chk1(fs, 1'h1);
        end
        if (video_present_in) chk1(par, interlaced ? ~f2 : 1'h1);
        if (video_present_in) exp_q.push_back(nl - 3);
    endtask

    task automatic run_test(input vst_format_t fm, input logic il, input int nf,
                            input logic vi);
        int e;
        @(negedge ref_clk);
        sys_rst    = 1'h1;
        format_sel = fm;
        interlaced = il;
        repeat (12) @(negedge ref_clk);
        check({10'h000, cs, ls, fs, bp, par, fw}, 16'h003f);
        sys_rst = 1'h0;
        exp_q.delete();
        for (int f = 1; f <= nf; f++) begin
            lfsr = lfsr_next(lfsr);
            field(14 + int'(lfsr[1:0]), vi && f == 1);
            if (f > 1) begin
                e = exp_q.pop_front();
                check({5'h00, rx_word}, 16'(e));
            end
        end
        $display("test format=%0d done, checks=%0d", fm, n_checks);
    endtask

    initial begin
        ref_clk           = 1'h0;
        sys_rst           = 1'h1;
        sync_tip_in       = 1'h0;
        tri_pos_in        = 1'h0;
        video_present_in  = 1'h1;
        vert_interval_in  = 1'h0;
        field_two_in      = 1'h0;
        serration_mid_stb = 1'h0;
        format_sel        = VST_FMT_SD;
        interlaced        = 1'h0;
        lfsr              = 32'h0001824e;
        n_mismatch        = 0;
        n_checks          = 0;
        bp_run            = 0;
        bp_last           = 0;
        run_test(VST_FMT_SD, 1'h1, 3, 1'h1);
        run_test(VST_FMT_ED, 1'h0, 2, 1'h0);
        run_test(VST_FMT_HD, 1'h0, 2, 1'h0);
        // No video: outputs parked high, composite still follows the input
        video_present_in = 1'h0;
        run_test(VST_FMT_SD, 1'h1, 1, 1'h0);
        tally_and_finish();
    end

    // Expected run is near 90k cycles; this margin only catches a hang
    initial begin
        #600000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
